// *** hw/sle_lamp_encoder.sv ***
// Contract
// - ready/error pair: on-off normal, on-on minor, on-flash moderate, off-on/flash major.
// - minor error during online module change flashes ready, error steadily on.
// - initial processing flashes ready with 2s period, error off.
// - online module change without error flashes ready at 400ms, error off.
// - non-redundant: program lamp on running, flashing paused, off stopped or stop error.
// - controlling member uses the same run, pause, stop program lamp encoding.
// - backup member in backup mode: on/flash only when both systems execute.
// - backup member in separate mode: flash also while awaiting run transition.
// - roles undetermined: flash while awaiting switch run transition, otherwise off.
// - alarm lamp on while any alarm flag is set, off otherwise.
// - battery lamp flashes while battery low, off otherwise.
// - card lamp on available, flashing readying, off unavailable or absent.
// - role taken from companion unit: control lamp on controls, standby lamp standby.
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "sle_defines.svh"

module sle_lamp_encoder
   import sle_pkg::*;
#(
   parameter int unsigned FAST_HALF_CYC = `SLE_FAST_HALF_CYC,
   parameter int unsigned SLOW_RATIO    = `SLE_SLOW_RATIO
) (
   input  wire logic         clk_sys,
   input  wire logic         nrst,
   // internal status
   input  wire sle_sev_type  fault_severity,
   input  wire logic         major_fault_flash,
   input  wire logic         online_change,
   input  wire logic         initial_processing,
   input  wire sle_prg_type  program_state,
   input  wire logic         stop_error,
   input  wire logic         await_run_transition,
   input  wire logic         redundant_en,
   input  wire logic         separate_mode,
   input  wire logic         peer_executing,
   input  wire logic         alarm_flag_any,
   input  wire logic         cell_low,
   input  wire sle_card_type card_state,
   // companion redundancy unit lamps (asynchronous)
   input  wire logic         companion_ctrl_lamp,
   input  wire logic         companion_backup_member_lamp,
   // register port
   input  wire logic [7:0]   reg_addr,
   input  wire logic [31:0]  reg_wr_data,
   input  wire logic         reg_wr_en,
   input  wire logic         reg_rd_en,
   output logic [31:0]       reg_rd_data,
   output logic              irq,
   // lamps
   output logic              operational_lamp,
   output logic              fault_lamp,
   output logic              program_state_lamp,
   output logic              alarm_flag_lamp,
   output logic              cell_low_lamp,
   output logic              card_available_lamp
);

   sle_state_type st_reg;
   sle_state_type st_next;

   logic        ready_lvl;
   logic        error_lvl;
   logic        prog_lvl;
   logic        card_lvl;

   sle_pat_type ready_pat;
   sle_pat_type error_pat;
   sle_pat_type prog_pat;
   sle_pat_type card_pat;
   sle_pat_type run_pat;
   logic        fault_now;
   logic [2:0]  events;
   logic [2:0]  w1c;

   // run/pause/stop encoding shared by single and controlling member
   always_comb begin
      run_pat = SLE_PAT_OFF;
      case (program_state)
         SLE_PRG_RUN:   run_pat = SLE_PAT_ON;
         SLE_PRG_PAUSE: run_pat = SLE_PAT_FAST;
         SLE_PRG_STOP:  run_pat = SLE_PAT_OFF;
         default:       run_pat = SLE_PAT_OFF;
      endcase
   end

   always_comb begin
      ready_pat = SLE_PAT_ON;
      error_pat = SLE_PAT_OFF;
      if (initial_processing) begin
         ready_pat = SLE_PAT_SLOW;
         error_pat = SLE_PAT_OFF;
      end else begin
         case (fault_severity)
            SLE_SEV_NORMAL: begin
               ready_pat = online_change ? SLE_PAT_FAST : SLE_PAT_ON;
               error_pat = SLE_PAT_OFF;
            end
            SLE_SEV_MINOR: begin
               ready_pat = online_change ? SLE_PAT_FAST : SLE_PAT_ON;
               error_pat = SLE_PAT_ON;
            end
            SLE_SEV_MODERATE: begin
               ready_pat = SLE_PAT_ON;
               error_pat = SLE_PAT_FAST;
            end
            SLE_SEV_MAJOR: begin
               ready_pat = SLE_PAT_OFF;
               error_pat = major_fault_flash ? SLE_PAT_FAST : SLE_PAT_ON;
            end
            default: begin
               ready_pat = SLE_PAT_OFF;
               error_pat = SLE_PAT_ON;
            end
         endcase
      end
   end

   always_comb begin
      prog_pat = SLE_PAT_OFF;
      case (st_reg.role)
         SLE_ROLE_SINGLE:  prog_pat = run_pat;
         SLE_ROLE_CONTROL: prog_pat = run_pat;
         SLE_ROLE_BACKUP: begin
            if (separate_mode) begin
               if (program_state == SLE_PRG_RUN) begin
                  prog_pat = SLE_PAT_ON;
               end else if (program_state == SLE_PRG_PAUSE || await_run_transition) begin
                  prog_pat = SLE_PAT_FAST;
               end else begin
                  prog_pat = SLE_PAT_OFF;
               end
            end else begin
               prog_pat = peer_executing ? run_pat : SLE_PAT_OFF;
            end
         end
         SLE_ROLE_UNKNOWN: prog_pat = await_run_transition ? SLE_PAT_FAST : SLE_PAT_OFF;
         default:          prog_pat = SLE_PAT_OFF;
      endcase
      if (stop_error) begin
         prog_pat = SLE_PAT_OFF;
      end
   end

   always_comb begin
      card_pat = SLE_PAT_OFF;
      case (card_state)
         SLE_CARD_AVAIL:    card_pat = SLE_PAT_ON;
         SLE_CARD_READYING: card_pat = SLE_PAT_FAST;
         SLE_CARD_UNAVAIL:  card_pat = SLE_PAT_OFF;
         SLE_CARD_ABSENT:   card_pat = SLE_PAT_OFF;
         default:           card_pat = SLE_PAT_OFF;
      endcase
   end

   // every flashing lamp reads the same phase flops, so they stay in phase
   sle_pat_level i_sle_pat_level_ready (
      .pat     (ready_pat),
      .fast_ph (st_reg.fast_ph),
      .slow_ph (st_reg.slow_ph),
      .lvl     (ready_lvl)
   );
   sle_pat_level i_sle_pat_level_error (
      .pat     (error_pat),
      .fast_ph (st_reg.fast_ph),
      .slow_ph (st_reg.slow_ph),
      .lvl     (error_lvl)
   );
   sle_pat_level i_sle_pat_level_prog (
      .pat     (prog_pat),
      .fast_ph (st_reg.fast_ph),
      .slow_ph (st_reg.slow_ph),
      .lvl     (prog_lvl)
   );
   sle_pat_level i_sle_pat_level_card (
      .pat     (card_pat),
      .fast_ph (st_reg.fast_ph),
      .slow_ph (st_reg.slow_ph),
      .lvl     (card_lvl)
   );

   assign fault_now = (fault_severity != SLE_SEV_NORMAL);
   always_comb begin
      events = 3'h0;
      events[`SLE_EV_FAULT] = fault_now && !st_reg.fault_prev;
      events[`SLE_EV_CELL]  = cell_low && !st_reg.cell_prev;
      events[`SLE_EV_ALARM] = alarm_flag_any && !st_reg.alarm_prev;
      w1c = 3'h0;
      if (reg_wr_en && reg_addr == `SLE_ADDR_STATUS) begin
         w1c = reg_wr_data[`SLE_EV_W-1:0];
      end
   end

   always_comb begin
      st_next = st_reg;

      // single timebase: fast phase per half-period, slow phase every SLOW_RATIO halves
      if (st_reg.tick_cnt >= FAST_HALF_CYC - 1) begin
         st_next.tick_cnt = 32'h0;
         st_next.fast_ph  = !st_reg.fast_ph;
         if (st_reg.ratio_cnt >= 8'(SLOW_RATIO - 1)) begin
            st_next.ratio_cnt = 8'h0;
            st_next.slow_ph   = !st_reg.slow_ph;
         end else begin
            st_next.ratio_cnt = st_reg.ratio_cnt + 8'h1;
         end
      end else begin
         st_next.tick_cnt = st_reg.tick_cnt + 32'h1;
      end

      // companion lamps pass two flip-flops before use
      st_next.ctrl_sync = {st_reg.ctrl_sync[0], companion_ctrl_lamp};
      st_next.sby_sync  = {st_reg.sby_sync[0], companion_backup_member_lamp};
      if (!redundant_en) begin
         st_next.role = SLE_ROLE_SINGLE;
      end else if (st_reg.ctrl_sync[1]) begin
         st_next.role = SLE_ROLE_CONTROL;
      end else if (st_reg.sby_sync[1]) begin
         st_next.role = SLE_ROLE_BACKUP;
      end else begin
         st_next.role = SLE_ROLE_UNKNOWN;
      end

      st_next.operational_lamp    = ready_lvl;
      st_next.fault_lamp          = error_lvl;
      st_next.program_state_lamp  = prog_lvl;
      st_next.alarm_flag_lamp     = alarm_flag_any;
      st_next.cell_low_lamp       = cell_low && st_reg.fast_ph;
      st_next.card_available_lamp = card_lvl;

      // sticky events, set wins over clear
      st_next.fault_prev = fault_now;
      st_next.cell_prev  = cell_low;
      st_next.alarm_prev = alarm_flag_any;
      st_next.status     = (st_reg.status & ~w1c) | events;
      if (reg_wr_en && reg_addr == `SLE_ADDR_MASK) begin
         st_next.mask = reg_wr_data[`SLE_EV_W-1:0];
      end
      st_next.irq = |(st_next.status & st_next.mask);

      st_next.rd_data = 32'h0;
      if (reg_rd_en) begin
         case (reg_addr)
            `SLE_ADDR_STATUS: st_next.rd_data = {29'h0, st_reg.status};
            `SLE_ADDR_MASK:   st_next.rd_data = {29'h0, st_reg.mask};
            `SLE_ADDR_LAMPS:  st_next.rd_data = {22'h0, st_reg.role,
                                                 2'h0,
                                                 st_reg.card_available_lamp,
                                                 st_reg.cell_low_lamp,
                                                 st_reg.alarm_flag_lamp,
                                                 st_reg.program_state_lamp,
                                                 st_reg.fault_lamp,
                                                 st_reg.operational_lamp};
            default:          st_next.rd_data = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         st_reg        <= '0;
         st_reg.status <= `SLE_STATUS_RST;
         st_reg.mask   <= `SLE_MASK_RST;
         st_reg.role   <= SLE_ROLE_SINGLE;
      end else begin
         st_reg <= st_next;
      end
   end

   assign reg_rd_data         = st_reg.rd_data;
   assign irq                 = st_reg.irq;
   assign operational_lamp    = st_reg.operational_lamp;
   assign fault_lamp          = st_reg.fault_lamp;
   assign program_state_lamp  = st_reg.program_state_lamp;
   assign alarm_flag_lamp     = st_reg.alarm_flag_lamp;
   assign cell_low_lamp       = st_reg.cell_low_lamp;
   assign card_available_lamp = st_reg.card_available_lamp;

endmodule : sle_lamp_encoder

// one lamp's level from its pattern and the shared flash phases
module sle_pat_level
   import sle_pkg::*;
(
   input  wire sle_pat_type pat,
   input  wire logic        fast_ph,
   input  wire logic        slow_ph,
   output logic             lvl
);

   always_comb begin
      lvl = 1'b0;
      case (pat)
         SLE_PAT_OFF:  lvl = 1'b0;
         SLE_PAT_ON:   lvl = 1'b1;
         SLE_PAT_FAST: lvl = fast_ph;
         SLE_PAT_SLOW: lvl = slow_ph;
         default:      lvl = 1'b0;
      endcase
   end

endmodule : sle_pat_level

// *** hw/sle_defines.svh ***
`ifndef SLE_DEFINES_SVH
`define SLE_DEFINES_SVH

// timing
`define SLE_CLK_KHZ          125000
`define SLE_FAST_HALF_MS     200
`define SLE_SLOW_HALF_MS     1000
`define SLE_FAST_HALF_CYC    (`SLE_FAST_HALF_MS * `SLE_CLK_KHZ)
`define SLE_SLOW_RATIO       (`SLE_SLOW_HALF_MS / `SLE_FAST_HALF_MS)

// register offsets
`define SLE_ADDR_STATUS      8'h00
`define SLE_ADDR_MASK        8'h04
`define SLE_ADDR_LAMPS       8'h08

// event bit positions
`define SLE_EV_FAULT         0
`define SLE_EV_CELL          1
`define SLE_EV_ALARM         2
`define SLE_EV_W             3

// reset values
`define SLE_MASK_RST         3'h0
`define SLE_STATUS_RST       3'h0

`endif

// *** hw/sle_pkg.sv ***
package sle_pkg;

   typedef enum logic [1:0] {
      SLE_SEV_NORMAL,
      SLE_SEV_MINOR,
      SLE_SEV_MODERATE,
      SLE_SEV_MAJOR
   } sle_sev_type;

   typedef enum logic [1:0] {
      SLE_PRG_STOP,
      SLE_PRG_RUN,
      SLE_PRG_PAUSE
   } sle_prg_type;

   typedef enum logic [1:0] {
      SLE_CARD_ABSENT,
      SLE_CARD_UNAVAIL,
      SLE_CARD_READYING,
      SLE_CARD_AVAIL
   } sle_card_type;

   typedef enum logic [1:0] {
      SLE_PAT_OFF,
      SLE_PAT_ON,
      SLE_PAT_FAST,
      SLE_PAT_SLOW
   } sle_pat_type;

   typedef enum logic [1:0] {
      SLE_ROLE_SINGLE,
      SLE_ROLE_CONTROL,
      SLE_ROLE_BACKUP,
      SLE_ROLE_UNKNOWN
   } sle_role_type;

   typedef struct packed {
      logic [31:0] tick_cnt;
      logic [7:0]  ratio_cnt;
      logic        fast_ph;
      logic        slow_ph;
      logic [1:0]  ctrl_sync;
      logic [1:0]  sby_sync;
      logic        fault_prev;
      logic        cell_prev;
      logic        alarm_prev;
      logic [2:0]  status;
      logic [2:0]  mask;
      logic        irq;
      logic [31:0] rd_data;
      logic        operational_lamp;
      logic        fault_lamp;
      logic        program_state_lamp;
      logic        alarm_flag_lamp;
      logic        cell_low_lamp;
      logic        card_available_lamp;
      sle_role_type role;
   } sle_state_type;

endpackage : sle_pkg

// *** sim/sle_lamp_chk.sv ***
`timescale 1ns/1ps
module sle_lamp_chk
   import sle_pkg::*;
(
   input wire logic         clk_sys,
   input wire logic         nrst,
   input wire sle_sev_type  fault_severity,
   input wire logic         online_change,
   input wire logic         initial_processing,
   input wire logic         stop_error,
   input wire logic         alarm_flag_any,
   input wire logic         cell_low,
   input wire sle_card_type card_state,
   input wire logic         operational_lamp,
   input wire logic         fault_lamp,
   input wire logic         program_state_lamp,
   input wire logic         alarm_flag_lamp,
   input wire logic         cell_low_lamp,
   input wire logic         card_available_lamp
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   a_ready_normal: assert property (
      nrst && fault_severity == SLE_SEV_NORMAL && !online_change && !initial_processing
      |=> operational_lamp && !fault_lamp) else $error("normal pair wrong");
   a_minor_both_on: assert property (
      nrst && fault_severity == SLE_SEV_MINOR && !online_change && !initial_processing
      |=> operational_lamp && fault_lamp) else $error("minor pair wrong");
   a_init_fault_off: assert property (initial_processing |=> !fault_lamp)
      else $error("fault lamp lit in initial processing");
   a_stop_prog_off: assert property (stop_error |=> !program_state_lamp)
      else $error("program lamp lit after stop error");
   a_alarm_lamp_on: assert property (nrst && alarm_flag_any |=> alarm_flag_lamp)
      else $error("alarm lamp dark");
   a_cell_lamp_off: assert property (!cell_low |=> !cell_low_lamp)
      else $error("cell lamp lit");
   a_card_lamp_on: assert property (nrst && card_state == SLE_CARD_AVAIL |=> card_available_lamp)
      else $error("card lamp dark");
   a_card_lamp_off: assert property (
      card_state inside {SLE_CARD_ABSENT, SLE_CARD_UNAVAIL} |=> !card_available_lamp)
      else $error("card lamp lit");
   a_flash_in_phase: assert property (
      cell_low && card_state == SLE_CARD_READYING |=> cell_low_lamp == card_available_lamp)
      else $error("flash lamps out of phase");
endmodule : sle_lamp_chk

bind sle_lamp_encoder sle_lamp_chk i_sle_lamp_chk (.clk_sys, .nrst, .fault_severity, .online_change,
   .initial_processing, .stop_error, .alarm_flag_any, .cell_low, .card_state, .operational_lamp, .fault_lamp,
   .program_state_lamp, .alarm_flag_lamp, .cell_low_lamp, .card_available_lamp);

// *** sim/test_sle_lamp_encoder.sv ***
`timescale 1ns/1ps
`include "sle_defines.svh"
module test_sle_lamp_encoder
   import sle_pkg::*;
();
   sle_sev_type  fault_severity = SLE_SEV_NORMAL;
   sle_prg_type  program_state  = SLE_PRG_STOP;
   sle_card_type card_state     = SLE_CARD_ABSENT;
   logic         clk_sys = 1'b0, nrst = 1'b0, reg_wr_en = 1'b0, reg_rd_en = 1'b0;
   logic [2:0]   sv = 3'h0;
   logic [6:0]   pv = 7'h00;
   logic [1:0]   mv = 2'h0;
   logic [7:0]   reg_addr = 8'h00;
   logic [31:0]  reg_wr_data = 32'h0, reg_rd_data, rd;
   logic         irq, operational_lamp, fault_lamp, program_state_lamp;
   logic         alarm_flag_lamp, cell_low_lamp, card_available_lamp;
   wire logic    major_fault_flash, online_change, initial_processing, stop_error, await_run_transition;
   wire logic    redundant_en, separate_mode, peer_executing, companion_ctrl_lamp, companion_backup_member_lamp;
   wire logic    alarm_flag_any, cell_low;
   wire logic [5:0] lv = {card_available_lamp, cell_low_lamp, alarm_flag_lamp, program_state_lamp,
                          fault_lamp, operational_lamp};
   int           num_errors = 0, checked = 0;
   sle_pat_type  pat [6];
   assign {major_fault_flash, online_change, initial_processing} = sv;
   assign {stop_error, await_run_transition, redundant_en, separate_mode, peer_executing,
           companion_ctrl_lamp, companion_backup_member_lamp} = pv;
   assign {alarm_flag_any, cell_low} = mv;
   sle_lamp_encoder #(.FAST_HALF_CYC(10), .SLOW_RATIO(5)) i_sle_lamp_encoder (.clk_sys, .nrst,
      .fault_severity, .major_fault_flash, .online_change, .initial_processing, .program_state, .stop_error,
      .await_run_transition, .redundant_en, .separate_mode, .peer_executing, .alarm_flag_any, .cell_low,
      .card_state, .companion_ctrl_lamp, .companion_backup_member_lamp, .reg_addr, .reg_wr_data, .reg_wr_en,
      .reg_rd_en, .reg_rd_data, .irq, .operational_lamp, .fault_lamp, .program_state_lamp, .alarm_flag_lamp,
      .cell_low_lamp, .card_available_lamp);
   initial forever #4 clk_sys = ~clk_sys;
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check
   task give_verdict;
      if (num_errors == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : give_verdict
   task rd_reg(input logic [7:0] a);
      @(posedge clk_sys);
      reg_rd_en <= 1'b1;
      reg_addr  <= a;
      @(posedge clk_sys);
      reg_rd_en <= 1'b0;
      #1;
      rd = reg_rd_data;
   endtask : rd_reg
   task wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_wr_en   <= 1'b1;
      reg_addr    <= a;
      reg_wr_data <= d;
      @(posedge clk_sys);
      reg_wr_en <= 1'b0;
   endtask : wr_reg
   // classify each lamp over a 100-cycle window: off, on, fast or slow flash
   task measure;
      logic [5:0] now, last;
      int         hi [6], ed [6];
      hi = '{default: 0};
      ed = '{default: 0};
      repeat (5) @(posedge clk_sys);
      #1;
      last = lv;
      repeat (100) begin
         @(posedge clk_sys);
         #1;
         now = lv;
         for (int i = 0; i < 6; i++) begin
            hi[i] += int'(now[i]);
            ed[i] += int'(now[i] != last[i]);
         end
         last = now;
      end
      for (int i = 0; i < 6; i++) begin
         pat[i] = hi[i] == 0 ? SLE_PAT_OFF : hi[i] == 100 ? SLE_PAT_ON : ed[i] > 5 ? SLE_PAT_FAST : SLE_PAT_SLOW;
      end
   endtask : measure
   // v: major flash, online change, initial processing
   task rdy(input sle_sev_type s, input logic [2:0] v, input sle_pat_type eo, ef);
      @(posedge clk_sys);
      fault_severity <= s;
      sv             <= v;
      measure();
      check(pat[0], eo);
      check(pat[1], ef);
   endtask : rdy
   // v: stop error, await run, redundant, separate, peer, ctrl lamp, standby lamp
   task pc(input sle_prg_type p, input logic [6:0] v, input sle_pat_type ep);
      @(posedge clk_sys);
      program_state <= p;
      pv            <= v;
      measure();
      check(pat[2], ep);
   endtask : pc
   task mc(input logic [1:0] v, input sle_card_type c, input sle_pat_type ea, ec, ek);
      @(posedge clk_sys);
      mv         <= v;
      card_state <= c;
      measure();
      check(pat[3], ea);
      check(pat[4], ec);
      check(pat[5], ek);
   endtask : mc
   task role(input logic [6:0] v, input logic [1:0] e);
      @(posedge clk_sys);
      pv <= v;
      repeat (4) @(posedge clk_sys);
      rd_reg(`SLE_ADDR_LAMPS);
      check(rd[9:8], e);
   endtask : role
   initial begin
      #200000;
      num_errors++;
      give_verdict();
   end
   initial begin
      repeat (10) @(posedge clk_sys);
      nrst <= 1'b1;
      rd_reg(`SLE_ADDR_STATUS);
      check(rd, 32'h0);
      rd_reg(`SLE_ADDR_MASK);
      check(rd, 32'h0);
      wr_reg(`SLE_ADDR_MASK, 32'h7);
      wr_reg(8'h10, 32'hFF);
      rd_reg(8'h10);
      check(rd, 32'h0);
      @(posedge clk_sys);
      mv <= 2'h1;
      repeat (2) @(posedge clk_sys);
      rd_reg(`SLE_ADDR_STATUS);
      check(rd, 32'h2);
      check(irq, 1'b1);
      wr_reg(`SLE_ADDR_STATUS, 32'h2);
      wr_reg(`SLE_ADDR_MASK, 32'h3);
      mv <= 2'h3;
      repeat (2) @(posedge clk_sys);
      rd_reg(`SLE_ADDR_STATUS);
      check(rd, 32'h4);
      check(irq, 1'b0);
      wr_reg(`SLE_ADDR_STATUS, 32'h4);
      fault_severity <= SLE_SEV_MINOR;
      repeat (2) @(posedge clk_sys);
      check(irq, 1'b1);
      wr_reg(`SLE_ADDR_STATUS, 32'h1);
      rd_reg(`SLE_ADDR_STATUS);
      check(rd, 32'h0);
      check(irq, 1'b0);
      @(posedge clk_sys);
      nrst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      nrst <= 1'b1;
      rd_reg(`SLE_ADDR_MASK);
      check(rd, 32'h0);
      rdy(SLE_SEV_NORMAL, 3'b000, SLE_PAT_ON, SLE_PAT_OFF);
      rdy(SLE_SEV_MINOR, 3'b000, SLE_PAT_ON, SLE_PAT_ON);
      rdy(SLE_SEV_MODERATE, 3'b000, SLE_PAT_ON, SLE_PAT_FAST);
      rdy(SLE_SEV_MAJOR, 3'b000, SLE_PAT_OFF, SLE_PAT_ON);
      rdy(SLE_SEV_MAJOR, 3'b100, SLE_PAT_OFF, SLE_PAT_FAST);
      rdy(SLE_SEV_MINOR, 3'b010, SLE_PAT_FAST, SLE_PAT_ON);
      rdy(SLE_SEV_MAJOR, 3'b001, SLE_PAT_SLOW, SLE_PAT_OFF);
      rdy(SLE_SEV_NORMAL, 3'b010, SLE_PAT_FAST, SLE_PAT_OFF);
      pc(SLE_PRG_RUN, 7'b0000000, SLE_PAT_ON);
      pc(SLE_PRG_PAUSE, 7'b0000000, SLE_PAT_FAST);
      pc(SLE_PRG_RUN, 7'b1000000, SLE_PAT_OFF);
      pc(SLE_PRG_PAUSE, 7'b0010010, SLE_PAT_FAST);
      pc(SLE_PRG_STOP, 7'b0010010, SLE_PAT_OFF);
      pc(SLE_PRG_RUN, 7'b0010011, SLE_PAT_ON);
      pc(SLE_PRG_RUN, 7'b0010101, SLE_PAT_ON);
      pc(SLE_PRG_PAUSE, 7'b0010101, SLE_PAT_FAST);
      pc(SLE_PRG_RUN, 7'b0010001, SLE_PAT_OFF);
      pc(SLE_PRG_RUN, 7'b1010101, SLE_PAT_OFF);
      pc(SLE_PRG_RUN, 7'b0011001, SLE_PAT_ON);
      pc(SLE_PRG_STOP, 7'b0111001, SLE_PAT_FAST);
      pc(SLE_PRG_STOP, 7'b0011001, SLE_PAT_OFF);
      pc(SLE_PRG_STOP, 7'b0110000, SLE_PAT_FAST);
      pc(SLE_PRG_RUN, 7'b0010000, SLE_PAT_OFF);
      role(7'b0000000, 2'h0);
      role(7'b0010010, 2'h1);
      role(7'b0010001, 2'h2);
      role(7'b0010000, 2'h3);
      mc(2'h0, SLE_CARD_ABSENT, SLE_PAT_OFF, SLE_PAT_OFF, SLE_PAT_OFF);
      mc(2'h3, SLE_CARD_AVAIL, SLE_PAT_ON, SLE_PAT_FAST, SLE_PAT_ON);
      mc(2'h1, SLE_CARD_READYING, SLE_PAT_OFF, SLE_PAT_FAST, SLE_PAT_FAST);
      mc(2'h0, SLE_CARD_UNAVAIL, SLE_PAT_OFF, SLE_PAT_OFF, SLE_PAT_OFF);
      give_verdict();
   end
endmodule : test_sle_lamp_encoder
